// ### design/dfac_defs.vh
// Register map, field layout and timing constants for the antenna control block
`ifndef DFAC_DEFS_VH
`define DFAC_DEFS_VH

// ****************************************************************
// Register map
// ****************************************************************
`define DFAC_CFG_ADDR        12'h910
`define DFAC_OFS_ADDR        12'h914
`define DFAC_PAT_ADDR        12'h928
`define DFAC_CLR_ADDR        12'h92C
`define DFAC_CFG_RESET       32'h00023282
`define DFAC_OFS_RESET       32'h00000000
`define DFAC_CFG_MASK        32'h0F07FFBF
`define DFAC_OFS_MASK        32'h0FFF1FFF

// ****************************************************************
// Field layout
// ****************************************************************
`define DFAC_LEN_RANGE       5:0
`define DFAC_EXT_BIT         7
`define DFAC_SWSP_RANGE      11:8
`define DFAC_REFSP_RANGE     14:12
`define DFAC_FMT_BIT         15
`define DFAC_SMPSP_RANGE     18:16
`define DFAC_GAIN_RANGE      27:24
`define DFAC_SWOFS_RANGE     12:0
`define DFAC_SWOFS_SIGN      12
`define DFAC_SMPOFS_RANGE    27:16
`define DFAC_SMPOFS_SIGN     27

// ****************************************************************
// Pattern array and gain stages
// ****************************************************************
`define DFAC_PAT_DEPTH       6'd40
`define DFAC_PAT_LAST        6'd39
`define DFAC_LNA_MAX         4'd4
`define DFAC_MIX_MAX         4'd4
`define DFAC_AAF_MAX         4'd4

// ****************************************************************
// Timing: 16 MHz timing ticks derived from the 50 MHz clock
// ****************************************************************
`define DFAC_TICK_INC        6'd16
`define DFAC_TICK_MOD        6'd50
`define DFAC_TICK_MHZ        16
`define DFAC_UNIT_NS         8000
`define DFAC_REF_NS          12000
`define DFAC_SP4_TICKS       16'd64
`define DFAC_SP2_TICKS       16'd32
`define DFAC_SP1_TICKS       16'd16
`define DFAC_SP05_TICKS      16'd8
`define DFAC_SP025_TICKS     16'd4
`define DFAC_SP0125_TICKS    16'd2
`define DFAC_UNIT_SHIFT      7
`define DFAC_REF_TICKS       16'd192

`endif

// ### design/dfac_top.v
// Direction finding configuration, procedure timing and antenna pattern driver
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "dfac_defs.vh"

module dfac_top (
  input  wire        clock_i,
  input  wire        sys_rst_i,
  input  wire [11:0] reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [31:0] reg_rdata_o,
  input  wire        tx_mode_i,
  input  wire        crc_end_i,
  input  wire        payload_start_i,
  input  wire        inline_tone_info_parse_enable_i,
  input  wire [2:0]  inline_rx_spacing_first_i,
  input  wire [2:0]  inline_rx_spacing_second_i,
  input  wire [5:0]  parsed_length_units_i,
  input  wire        aoa_mode_i,
  input  wire        aod_short_slot_i,
  output reg  [7:0]  antenna_pins_o,
  output reg         sample_strobe_o,
  output wire        sample_format_o,
  output reg         cte_extension_o,
  output reg         procedure_active_o,
  output reg  [3:0]  low_noise_amp_gain_o,
  output reg  [3:0]  mixer_gain_o,
  output reg  [3:0]  antialias_filter_gain_o
);

  // ****************************************************************
  // Decoding functions
  // ****************************************************************
  // Sample spacing code to ticks; undefined codes fall back to the slowest
  function [15:0] smp_ticks;
    input [2:0] code;
    begin
      case (code)
        3'h1: smp_ticks = `DFAC_SP4_TICKS;
        3'h2: smp_ticks = `DFAC_SP2_TICKS;
        3'h3: smp_ticks = `DFAC_SP1_TICKS;
        3'h4: smp_ticks = `DFAC_SP05_TICKS;
        3'h5: smp_ticks = `DFAC_SP025_TICKS;
        3'h6: smp_ticks = `DFAC_SP0125_TICKS;
        default: smp_ticks = `DFAC_SP4_TICKS;
      endcase
    end
  endfunction

  function [15:0] sw_ticks;
    input [3:0] code;
    begin
      case (code)
        4'h1: sw_ticks = `DFAC_SP4_TICKS;
        4'h2: sw_ticks = `DFAC_SP2_TICKS;
        4'h3: sw_ticks = `DFAC_SP1_TICKS;
        default: sw_ticks = `DFAC_SP4_TICKS;
      endcase
    end
  endfunction

  function [3:0] min4;
    input [3:0] a;
    input [3:0] b;
    begin
      min4 = (a < b) ? a : b;
    end
  endfunction

  // ****************************************************************
  // Registers and pattern array
  // ****************************************************************
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN  = 1'b1;

  reg  [31:0]  cfg;
  reg  [31:0]  ofs;
  reg  [5:0]   pat_cnt;
  wire [319:0] pat_flat;
  wire         pat_wr;
  wire         pat_clr;
  wire         pat_full;

  assign pat_wr   = reg_wr_i && (reg_addr_i == `DFAC_PAT_ADDR);
  assign pat_clr  = reg_wr_i && (reg_addr_i == `DFAC_CLR_ADDR);
  assign pat_full = (pat_cnt == `DFAC_PAT_DEPTH);

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      cfg <= `DFAC_CFG_RESET;
      ofs <= `DFAC_OFS_RESET;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `DFAC_CFG_ADDR) begin
        cfg <= reg_wdata_i & `DFAC_CFG_MASK;
      end
      if (reg_addr_i == `DFAC_OFS_ADDR) begin
        ofs <= reg_wdata_i & `DFAC_OFS_MASK;
      end
    end
  end

  // Pattern append and clear; a write to a full array is dropped
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      pat_cnt <= 6'h00;
    end else if (pat_clr) begin
      pat_cnt <= 6'h00;
    end else if (pat_wr && !pat_full) begin
      pat_cnt <= pat_cnt + 6'h01;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `DFAC_PAT_DEPTH; gi = gi + 1) begin : g_pat
      reg [7:0] entry;
      always @(posedge clock_i) begin
        if (sys_rst_i) begin
          entry <= 8'h00;
        end else if (pat_wr && !pat_full && (pat_cnt == gi)) begin
          entry <= reg_wdata_i[7:0];
        end
      end
      assign pat_flat[gi*8 +: 8] = entry;
    end
  endgenerate

  // Read data stands in the cycle after the strobe only
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `DFAC_CFG_ADDR: reg_rdata_o <= cfg;
        `DFAC_OFS_ADDR: reg_rdata_o <= ofs;
        `DFAC_PAT_ADDR: reg_rdata_o <= {26'h0000000, pat_cnt};
        default:        reg_rdata_o <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_o <= 32'h00000000;
    end
  end

  assign sample_format_o = cfg[`DFAC_FMT_BIT];

  // ****************************************************************
  // 16 MHz timing tick
  // ****************************************************************
  // Fractional accumulator: 16 ticks per 50 clocks, jitter of one clock per tick
  // Sum is one bit wider: the accumulator reaches 48, and 48 plus 16 overflows six bits
  reg  [5:0] tick_acc;
  wire [6:0] tick_sum;
  wire [6:0] tick_wrap;
  wire       tick;

  assign tick_sum  = {1'b0, tick_acc} + {1'b0, `DFAC_TICK_INC};
  assign tick_wrap = tick_sum - {1'b0, `DFAC_TICK_MOD};
  assign tick      = (tick_sum >= {1'b0, `DFAC_TICK_MOD});

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      tick_acc <= 6'h00;
    end else if (tick) begin
      tick_acc <= tick_wrap[5:0];
    end else begin
      tick_acc <= tick_sum[5:0];
    end
  end

  // ****************************************************************
  // Start points computed at trigger
  // ****************************************************************
  wire        use_ext;
  wire        trigger;
  wire [5:0]  len_units;
  wire [15:0] len_ticks;
  wire [15:0] sw_start_w;
  wire [16:0] smp_sum;
  wire [15:0] smp_start_w;
  wire [3:0]  steps;
  wire [3:0]  lna_w;
  wire [3:0]  mix_w;
  wire [3:0]  aaf_w;

  assign use_ext = cfg[`DFAC_EXT_BIT];
  // trigger at CRC end or in payload
  assign trigger = use_ext ? crc_end_i : payload_start_i;
  assign len_units = (tx_mode_i || !inline_tone_info_parse_enable_i) ?
                     cfg[`DFAC_LEN_RANGE] : parsed_length_units_i;
  assign len_ticks = {10'h000, len_units} << `DFAC_UNIT_SHIFT;
  assign sw_start_w = ofs[`DFAC_SWOFS_SIGN] ? 16'h0000 : {3'h0, ofs[`DFAC_SWOFS_RANGE]};
  assign smp_sum = {1'b0, sw_start_w} + {1'b0, `DFAC_REF_TICKS} +
                   {{5{ofs[`DFAC_SMPOFS_SIGN]}}, ofs[`DFAC_SMPOFS_RANGE]};
  assign smp_start_w = smp_sum[16] ? 16'h0000 : smp_sum[15:0];
  assign steps = cfg[`DFAC_GAIN_RANGE];
  assign lna_w = min4(steps, `DFAC_LNA_MAX);
  assign mix_w = min4(steps - lna_w, `DFAC_MIX_MAX);
  assign aaf_w = min4(steps - lna_w - mix_w, `DFAC_AAF_MAX);

  // ****************************************************************
  // Procedure sequencer
  // ****************************************************************
  reg         state;
  reg  [15:0] elapsed;
  reg  [15:0] len_q;
  reg  [15:0] sw_start;
  reg  [15:0] smp_start;
  reg  [15:0] sw_cnt;
  reg  [15:0] smp_cnt;
  reg  [5:0]  ant_idx;
  reg         switching;
  reg         past_ref;
  wire [15:0] since_sw;
  wire [15:0] sw_int;
  wire [15:0] smp_int;
  wire [2:0]  swp_code;
  wire [5:0]  ant_next;

  assign since_sw = elapsed - sw_start;
  assign sw_int = sw_ticks(cfg[`DFAC_SWSP_RANGE]);
  // AoA at 2 us picks first field
  assign swp_code = !inline_tone_info_parse_enable_i ? cfg[`DFAC_SMPSP_RANGE] :
                    (aoa_mode_i ? ((cfg[`DFAC_SWSP_RANGE] == 4'h2) ?
                                   inline_rx_spacing_first_i : inline_rx_spacing_second_i) :
                     (aod_short_slot_i ? inline_rx_spacing_first_i :
                                         inline_rx_spacing_second_i));
  assign smp_int = past_ref ? smp_ticks(swp_code) : smp_ticks(cfg[`DFAC_REFSP_RANGE]);
  assign ant_next = ((ant_idx + 6'h01) >= pat_cnt) ? 6'h01 : (ant_idx + 6'h01);

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      state                   <= ST_IDLE;
      elapsed                 <= 16'h0000;
      len_q                   <= 16'h0000;
      sw_start                <= 16'h0000;
      smp_start               <= 16'h0000;
      sw_cnt                  <= 16'h0000;
      smp_cnt                 <= 16'h0000;
      ant_idx                 <= 6'h00;
      switching               <= 1'b0;
      past_ref                <= 1'b0;
      sample_strobe_o         <= 1'b0;
      procedure_active_o      <= 1'b0;
      cte_extension_o         <= 1'b0;
      low_noise_amp_gain_o    <= 4'h0;
      mixer_gain_o            <= 4'h0;
      antialias_filter_gain_o <= 4'h0;
    end else begin
      sample_strobe_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (trigger && (len_ticks != 16'h0000)) begin
            state                   <= ST_RUN;
            elapsed                 <= 16'h0000;
            len_q                   <= len_ticks;
            sw_start                <= sw_start_w;
            smp_start               <= smp_start_w;
            sw_cnt                  <= 16'h0000;
            smp_cnt                 <= 16'h0000;
            ant_idx                 <= 6'h00;
            switching               <= 1'b0;
            past_ref                <= 1'b0;
            procedure_active_o      <= 1'b1;
            cte_extension_o         <= use_ext && tx_mode_i;
            low_noise_amp_gain_o    <= lna_w;
            mixer_gain_o            <= mix_w;
            antialias_filter_gain_o <= aaf_w;
          end
        end
        ST_RUN: begin
          if (tick) begin
            elapsed <= elapsed + 16'h0001;
            if (elapsed == sw_start) begin
              switching <= 1'b1;
            end
            if (switching && !past_ref && (since_sw == `DFAC_REF_TICKS)) begin
              past_ref <= 1'b1;
              ant_idx  <= 6'h01;
              sw_cnt   <= 16'h0000;
            end else if (past_ref) begin
              if (sw_cnt == (sw_int - 16'h0001)) begin
                sw_cnt  <= 16'h0000;
                ant_idx <= ant_next;
              end else begin
                sw_cnt <= sw_cnt + 16'h0001;
              end
            end
            if (elapsed >= smp_start) begin
              if (smp_cnt == 16'h0000) begin
                sample_strobe_o <= 1'b1;
              end
              if (smp_cnt >= (smp_int - 16'h0001)) begin
                smp_cnt <= 16'h0000;
              end else begin
                smp_cnt <= smp_cnt + 16'h0001;
              end
            end
            if ((elapsed + 16'h0001) >= len_q) begin
              state                   <= ST_IDLE;
              switching               <= 1'b0;
              past_ref                <= 1'b0;
              procedure_active_o      <= 1'b0;
              cte_extension_o         <= 1'b0;
              low_noise_amp_gain_o    <= 4'h0;
              mixer_gain_o            <= 4'h0;
              antialias_filter_gain_o <= 4'h0;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Antenna pins
  // ****************************************************************
  // Lines stay low outside switching so no antenna is left selected when idle
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      antenna_pins_o <= 8'h00;
    end else if (switching && (state == ST_RUN)) begin
      antenna_pins_o <= pat_flat[ant_idx*8 +: 8];
    end else begin
      antenna_pins_o <= 8'h00;
    end
  end

endmodule // dfac_top

// ### bench/dfac_top_monitor.sv
// Port assertions for the antenna control block
`timescale 1ns/1ps
`include "dfac_defs.vh"
module dfac_top_monitor (
  input wire        clock_i,
  input wire        sys_rst_i,
  input wire [11:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire        reg_wr_i,
  input wire        reg_rd_i,
  input wire [31:0] reg_rdata_o,
  input wire        crc_end_i,
  input wire        payload_start_i,
  input wire [7:0]  antenna_pins_o,
  input wire        sample_strobe_o,
  input wire        sample_format_o,
  input wire        procedure_active_o,
  input wire [3:0]  low_noise_amp_gain_o,
  input wire [3:0]  mixer_gain_o,
  input wire [3:0]  antialias_filter_gain_o
);
  // ****
  // Shadow state
  // ****
  reg [5:0] cnt;
  reg       fmt;
  reg [3:0] backoff;
  wire      pat_wr = reg_wr_i && reg_addr_i == `DFAC_PAT_ADDR;
  wire      cfg_wr = reg_wr_i && reg_addr_i == `DFAC_CFG_ADDR;
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      cnt <= 6'h00;
      fmt <= 1'b0;
      backoff <= 4'h0;
    end else begin
      if (reg_wr_i && reg_addr_i == `DFAC_CLR_ADDR)
        cnt <= 6'h00;
      else if (pat_wr && cnt != `DFAC_PAT_DEPTH)
        cnt <= cnt + 6'h01;
      if (cfg_wr) begin
        fmt <= reg_wdata_i[`DFAC_FMT_BIT];
        backoff <= reg_wdata_i[`DFAC_GAIN_RANGE];
      end
    end
  end
  // ****
  // Assertions
  // ****
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  a_count_read: assert property (reg_rd_i && reg_addr_i == `DFAC_PAT_ADDR
    |=> reg_rdata_o == {26'h0, cnt}) else $error("pattern count read wrong");
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside read cycle");
  a_format_sel: assert property (sample_format_o == fmt)
    else $error("sample format differs from config");
  a_gain_total: assert property ($rose(procedure_active_o) |->
    {2'h0, low_noise_amp_gain_o} + {2'h0, mixer_gain_o} + {2'h0, antialias_filter_gain_o}
    == ((backoff > 4'hC) ? 6'h0C : {2'h0, backoff})) else $error("gain back-off sum wrong");
  a_mix_after: assert property (mixer_gain_o != 4'h0 |-> low_noise_amp_gain_o == `DFAC_LNA_MAX)
    else $error("mixer reduced before amplifier");
  a_aaf_after: assert property (antialias_filter_gain_o != 4'h0 |-> mixer_gain_o == `DFAC_MIX_MAX)
    else $error("filter reduced before mixer");
  a_start_trig: assert property ($rose(procedure_active_o) |->
    $past(crc_end_i || payload_start_i) || $past(crc_end_i || payload_start_i, 2))
    else $error("procedure started without trigger");
  a_pins_idle: assert property (!procedure_active_o && !$past(procedure_active_o)
    |-> antenna_pins_o == 8'h00) else $error("pins driven while idle");
  a_strobe_pulse: assert property (sample_strobe_o |=> !sample_strobe_o)
    else $error("sample strobe longer than one cycle");
  a_strobe_in: assert property (sample_strobe_o |-> procedure_active_o || $past(procedure_active_o))
    else $error("sample strobe outside procedure");
  c_start: cover property ($rose(procedure_active_o));
  c_count: cover property (reg_rd_i && reg_addr_i == `DFAC_PAT_ADDR);
  c_mixer: cover property (mixer_gain_o != 4'h0);
endmodule // dfac_top_monitor

bind dfac_top dfac_top_monitor i_dfac_top_monitor (.clock_i, .sys_rst_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .crc_end_i, .payload_start_i,
  .antenna_pins_o, .sample_strobe_o, .sample_format_o, .procedure_active_o,
  .low_noise_amp_gain_o, .mixer_gain_o, .antialias_filter_gain_o);

// ### bench/dfac_antenna_net.sv
// Model of the external antenna switch network on the pattern pins
`timescale 1ns/1ps
module dfac_antenna_net (
  input wire       clock_i,
  input wire       clr_i,
  input wire [7:0] antenna_pins_i
);
  logic [7:0] seq [$];
  logic [7:0] last = 8'h00;
  always @(posedge clock_i) begin
    if (clr_i) begin
      seq.delete();
      last <= 8'h00;
    end else if (antenna_pins_i != last) begin
      // Idle level is not a pattern, so it is not logged
      if (antenna_pins_i != 8'h00)
        seq.push_back(antenna_pins_i);
      last <= antenna_pins_i;
    end
  end
endmodule // dfac_antenna_net

// ### bench/dfac_top_test.sv
// Self-checking bench for the antenna control block
`timescale 1ns/1ps
`include "dfac_defs.vh"
module dfac_top_test;
  logic        clock_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0, rd = 1'b0, tx = 1'b1, crc = 1'b0, pay = 1'b0;
  logic        inl = 1'b0, aoa = 1'b0, aod1 = 1'b0, pclr = 1'b0;
  logic [2:0]  sp1 = 3'h4, sp2 = 3'h1;
  logic [5:0]  plen = 6'h03;
  wire  [31:0] rdata;
  wire  [7:0]  pins;
  wire         strobe, fmt, ext, act;
  wire  [3:0]  g_lna, g_mix, g_aaf;
  logic [3:0]  s_lna, s_mix, s_aaf;
  logic        s_ext;
  int          err_total = 0, total_checks = 0, cyc = 0, acyc, nstr, tstr, tpin;
  dfac_top i_dfac_top (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .tx_mode_i(tx),
    .crc_end_i(crc), .payload_start_i(pay), .inline_tone_info_parse_enable_i(inl),
    .inline_rx_spacing_first_i(sp1), .inline_rx_spacing_second_i(sp2),
    .parsed_length_units_i(plen), .aoa_mode_i(aoa), .aod_short_slot_i(aod1),
    .antenna_pins_o(pins), .sample_strobe_o(strobe), .sample_format_o(fmt),
    .cte_extension_o(ext), .procedure_active_o(act), .low_noise_amp_gain_o(g_lna),
    .mixer_gain_o(g_mix), .antialias_filter_gain_o(g_aaf));
  dfac_antenna_net i_dfac_antenna_net (.clock_i(clock_i), .clr_i(pclr), .antenna_pins_i(pins));
  always #10 clock_i = ~clock_i;
  // ****
  // Watchdog and procedure measurement
  // ****
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (act) begin
      acyc++;
      if (acyc == 1) begin
        s_lna = g_lna;
        s_mix = g_mix;
        s_aaf = g_aaf;
        s_ext = ext;
      end
      if (strobe && nstr++ == 0)
        tstr = acyc;
      if (pins != 8'h00 && tpin < 0)
        tpin = acyc;
    end
    // About 14k cycles of procedures, so the ceiling leaves ample room
    if (cyc == 40000) begin
      err_total++;
      stop_test();
    end
  end
  // ****
  // Shared tasks
  // ****
  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Tick accumulator jitters by a clock, so times get a small window
  task near(input string nm, input int exp, input int got);
    total_checks++;
    if (got < exp - 4 || got > exp + 4) begin
      err_total++;
      $display("[ERR] %s expected %0d seen %0d", nm, exp, got);
    end
  endtask
  task wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask
  task rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
    @(posedge clock_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    #1 chk(nm, e, rdata);
  endtask
  task run(input logic use_crc);
    #1 acyc = 0;
    nstr = 0;
    tstr = -1;
    tpin = -1;
    pclr <= 1'b1;
    @(posedge clock_i);
    pclr <= 1'b0;
    crc <= use_crc;
    pay <= !use_crc;
    @(posedge clock_i);
    crc <= 1'b0;
    pay <= 1'b0;
    repeat (3) @(posedge clock_i);
    while (act && acyc < 4000) @(posedge clock_i);
    repeat (2) @(posedge clock_i);
  endtask
  // ****
  // Scenarios
  // ****
  task t_regs;
    rd_chk("config reset", `DFAC_CFG_ADDR, `DFAC_CFG_RESET);
    rd_chk("offsets reset", `DFAC_OFS_ADDR, `DFAC_OFS_RESET);
    rd_chk("clear reads", `DFAC_CLR_ADDR, 32'h0);
    wr_reg(`DFAC_CFG_ADDR, 32'hFFFFFFFF);
    wr_reg(12'h918, 32'h0);
    rd_chk("unmapped", 12'h918, 32'h0);
    rd_chk("config mask", `DFAC_CFG_ADDR, `DFAC_CFG_MASK);
    chk("format mag", 32'h1, {31'h0, fmt}); // format select
    wr_reg(`DFAC_OFS_ADDR, 32'hFFFFFFFF);
    rd_chk("offsets mask", `DFAC_OFS_ADDR, `DFAC_OFS_MASK);
    wr_reg(`DFAC_CFG_ADDR, 32'h0);
    #1 chk("format iq", 32'h0, {31'h0, fmt}); // format select
  endtask
  task t_patterns;
    rd_chk("count reset", `DFAC_PAT_ADDR, 32'h0); // count read
    for (int i = 0; i < 41; i++)
      wr_reg(`DFAC_PAT_ADDR, 32'(i));
    rd_chk("count full", `DFAC_PAT_ADDR, 32'h28); // depth limit
    wr_reg(`DFAC_CLR_ADDR, 32'h0);
    rd_chk("count cleared", `DFAC_PAT_ADDR, 32'h0); // clear
    wr_reg(`DFAC_PAT_ADDR, 32'h1);
    wr_reg(`DFAC_PAT_ADDR, 32'h2);
    wr_reg(`DFAC_PAT_ADDR, 32'h4);
    rd_chk("count refill", `DFAC_PAT_ADDR, 32'h3); // append restarts
  endtask
  task t_switch;
    wr_reg(`DFAC_CFG_ADDR, 32'h06013383);
    wr_reg(`DFAC_OFS_ADDR, 32'h0F400000);
    run(1'b1);
    near("length", 1200, acyc); // duration
    chk("lna", 32'h4, {28'h0, s_lna}); // back-off
    chk("mixer", 32'h2, {28'h0, s_mix}); // order
    chk("filter", 32'h0, {28'h0, s_aaf}); // order
    chk("extension", 32'h1, {31'h0, s_ext}); // extension
    near("slots", 13, i_dfac_antenna_net.seq.size()); // 1us switching
    for (int i = 0; i < 5; i++)
      chk("pattern", (i == 0) ? 32'h1 : (i % 2 ? 32'h2 : 32'h4),
          {24'h0, i_dfac_antenna_net.seq[i]}); // wrap
    near("samples", 15, nstr); // spacing
  endtask
  task t_offsets;
    logic [31:0] ofs [3] = '{32'h0, 32'h000000A0, 32'h08001000};
    int sw [3] = '{0, 160, 0};
    int sm [3] = '{192, 352, 0};
    wr_reg(`DFAC_CFG_ADDR, 32'h0A011184);
    // First tick lands one to four cycles after start, output shows one or two later
    for (int i = 0; i < 3; i++) begin
      wr_reg(`DFAC_OFS_ADDR, ofs[i]);
      run(1'b1);
      near("switch start", 4 + sw[i] * 50 / 16, tpin); // offset
      near("sample start", 4 + sm[i] * 50 / 16, tstr); // offset
    end
    chk("filter split", 32'h2, {28'h0, s_aaf}); // filter last
  endtask
  task t_trigger;
    wr_reg(`DFAC_CFG_ADDR, 32'h00011103);
    wr_reg(`DFAC_OFS_ADDR, 32'h0);
    run(1'b1);
    near("crc ignored", 0, acyc); // payload mode
    tx <= 1'b0;
    inl <= 1'b1;
    plen <= 6'h02;
    run(1'b0);
    near("rx parsed", 800, acyc); // parsed length
    chk("no extension", 32'h0, {31'h0, s_ext}); // payload mode
    tx <= 1'b1;
    run(1'b0);
    near("tx length", 1200, acyc); // transmit
    tx <= 1'b0;
    inl <= 1'b0;
    run(1'b0);
    near("rx length", 1200, acyc); // receive
  endtask
  task t_inline;
    plen <= 6'h03;
    inl <= 1'b1;
    aoa <= 1'b1;
    wr_reg(`DFAC_OFS_ADDR, 32'h0F400000);
    wr_reg(`DFAC_CFG_ADDR, 32'h00011283);
    run(1'b1);
    near("aoa 2us", 27, nstr); // first field
    wr_reg(`DFAC_CFG_ADDR, 32'h00011183);
    run(1'b1);
    near("aoa 4us", 6, nstr); // second field
    aoa <= 1'b0;
    aod1 <= 1'b1;
    run(1'b1);
    near("aod short", 27, nstr); // first field
    inl <= 1'b0;
    wr_reg(`DFAC_CFG_ADDR, 32'h00031183);
    run(1'b1);
    near("no inline", 15, nstr); // config sample spacing
  endtask
  initial begin
    repeat (3) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    t_regs;
    t_patterns;
    t_switch;
    t_offsets;
    t_trigger;
    t_inline;
    stop_test;
  end
endmodule // dfac_top_test
